// >>> fci_pkg.sv
package fci_pkg;
    // Clock and bus widths
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;

    // Bus cycle timing; a least time rounds up to whole cycles
    localparam int ACCESS_NS = 120;
    localparam int RD_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;
    localparam int WE_LOW_NS = 50;
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_HIGH_NS = 30;
    localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Wait after read/reset from erase mode (least time, rounded up)
    localparam int RESET_WAIT_US = 10;
    localparam int RESET_WAIT_CYC = (RESET_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Erase collection window, shortest value, rounded down
    localparam int ERASE_WIN_US = 80;
    localparam int ERASE_WIN_CYC = (ERASE_WIN_US * 1000) / CLK_PERIOD_NS;

    // Unlock and command addresses, byte and word configuration
    localparam logic [ADDR_W-1:0] UNLOCK1_BYTE_ADDR = 17'h0AAAA;
    localparam logic [ADDR_W-1:0] UNLOCK1_WORD_ADDR = 17'h05555;
    localparam logic [ADDR_W-1:0] UNLOCK2_BYTE_ADDR = 17'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK2_WORD_ADDR = 17'h02AAA;

    // Command data codes
    localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] READ_RESET_CMD = 8'hF0;
    localparam logic [7:0] IDENT_QUERY_CMD = 8'h90;
    localparam logic [7:0] PROGRAM_CMD = 8'hA0;
    localparam logic [7:0] ERASE_SETUP_CMD = 8'h80;
    localparam logic [7:0] BLOCK_ERASE_CMD = 8'h30;

    // Status bit positions
    localparam int POLLING_STATUS_BIT = 7;
    localparam int TOGGLE_STATUS_BIT = 6;
    localparam int ERROR_STATUS_BIT = 5;
    localparam int ERASE_TIMER_STATUS_BIT = 3;
    localparam int BLOCK_TOGGLE_STATUS_BIT = 2;

    // User operations
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_RESET = 3'h1,
        OP_IDENT_QUERY = 3'h2,
        OP_PROGRAM = 3'h3,
        OP_BLOCK_ERASE = 3'h4,
        OP_ERASE_ADD = 3'h5,
        OP_POLL = 3'h6,
        OP_SPARE = 3'h7
    } fci_op_t;
endpackage : fci_pkg

// >>> fci_cyc_if.sv
`timescale 1ns/10ps
interface fci_cyc_if;
    import fci_pkg::*;
    logic req;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic byte_mode;
    logic done;
    logic [DATA_W-1:0] rdata;

    modport ctl (output req, output wr, output addr, output wdata, output byte_mode,
                 input done, input rdata);
    modport eng (input req, input wr, input addr, input wdata, input byte_mode,
                 output done, output rdata);
endinterface : fci_cyc_if

// >>> fci_bus_cycle.sv
`timescale 1ns/10ps
module fci_bus_cycle (
    input wire logic mclk_i,
    input wire logic rstn_i,
    fci_cyc_if.eng cyc,
    output logic [15:0] fl_addr_o,
    output logic [15:0] fl_dq_o,
    output logic [2:0] fl_dq_oe_o,
    input wire logic [15:0] fl_dq_i,
    output logic fl_ce_n_o,
    output logic fl_oe_n_o,
    output logic fl_we_n_o
);
    import fci_pkg::*;

    typedef enum logic [2:0] {
        B_IDLE = 3'h0,
        B_SETUP = 3'h1,
        B_PULSE = 3'h2,
        B_HOLD = 3'h3,
        B_READ = 3'h4
    } fci_bstate_t;

    localparam logic [7:0] RD_LAST = 8'(RD_CYC + SYNC_STAGES - 1);
    localparam logic [7:0] WL_LAST = 8'(WE_LOW_CYC - 1);
    localparam logic [7:0] WH_LAST = 8'(WE_HIGH_CYC - 1);

    fci_bstate_t state, next_state;
    logic [7:0] cnt, next_cnt;
    logic wr, next_wr;
    logic [15:0] addr, next_addr;
    logic [15:0] dq, next_dq;
    logic [2:0] oe, next_oe;
    logic ce_n, next_ce_n;
    logic oen, next_oen;
    logic we_n, next_we_n;
    logic done, next_done;
    logic [15:0] rdata, next_rdata;
    logic [15:0] dq_meta, dq_sync;

    // Pin data passes two flops before anything reads it
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dq_meta <= 16'h0000;
            dq_sync <= 16'h0000;
        end else begin
            dq_meta <= fl_dq_i;
            dq_sync <= dq_meta;
        end
    end

    // One write or read strobe per request
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_wr = wr;
        next_addr = addr;
        next_dq = dq;
        next_oe = oe;
        next_ce_n = ce_n;
        next_oen = oen;
        next_we_n = we_n;
        next_done = 1'b0;
        next_rdata = rdata;
        unique case (state)
            B_IDLE: begin
                if (cyc.req) begin
                    next_wr = cyc.wr;
                    // In byte mode the lowest bit rides on DQ15 as the extra address line
                    next_addr = cyc.byte_mode ? cyc.addr[16:1] : cyc.addr[15:0];
                    next_dq = cyc.byte_mode ? {cyc.addr[0], 7'h00, cyc.wdata[7:0]} : cyc.wdata;
                    next_oe = cyc.byte_mode ? {1'b1, 1'b0, cyc.wr} : {3{cyc.wr}};
                    next_ce_n = 1'b0;
                    next_cnt = 8'h00;
                    next_state = B_SETUP;
                end
            end
            B_SETUP: begin
                // Address settles one cycle before the falling strobe
                if (wr) begin
                    next_we_n = 1'b0;
                    next_state = B_PULSE;
                end else begin
                    next_oen = 1'b0;
                    next_state = B_READ;
                end
            end
            B_PULSE: begin
                next_cnt = cnt + 8'h01;
                if (cnt == WL_LAST) begin
                    next_we_n = 1'b1;
                    next_cnt = 8'h00;
                    next_state = B_HOLD;
                end
            end
            B_HOLD: begin
                // Data stays driven past the rising strobe so it is captured cleanly
                next_cnt = cnt + 8'h01;
                next_ce_n = 1'b1;
                if (cnt == WH_LAST) begin
                    next_oe = 3'h0;
                    next_done = 1'b1;
                    next_state = B_IDLE;
                end
            end
            B_READ: begin
                // Access time plus the synchroniser delay
                next_cnt = cnt + 8'h01;
                if (cnt == RD_LAST) begin
                    next_rdata = dq_sync;
                    next_oen = 1'b1;
                    next_ce_n = 1'b1;
                    next_oe = 3'h0;
                    next_done = 1'b1;
                    next_state = B_IDLE;
                end
            end
            default: next_state = B_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= B_IDLE;
            cnt <= 8'h00;
            wr <= 1'b0;
            addr <= 16'h0000;
            dq <= 16'h0000;
            oe <= 3'h0;
            ce_n <= 1'b1;
            oen <= 1'b1;
            we_n <= 1'b1;
            done <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            wr <= next_wr;
            addr <= next_addr;
            dq <= next_dq;
            oe <= next_oe;
            ce_n <= next_ce_n;
            oen <= next_oen;
            we_n <= next_we_n;
            done <= next_done;
            rdata <= next_rdata;
        end
    end

    assign fl_addr_o = addr;
    assign fl_dq_o = dq;
    assign fl_dq_oe_o = oe;
    assign fl_ce_n_o = ce_n;
    assign fl_oe_n_o = oen;
    assign fl_we_n_o = we_n;
    assign cyc.done = done;
    assign cyc.rdata = rdata;
endmodule : fci_bus_cycle

// >>> fci_host.sv
`timescale 1ns/10ps
// Overview of operation
// - First unlock writes AAh to AAAAh (byte) or 5555h (word).
// - Second unlock writes 55h to 555h (byte) or 2AAAh (word).
// - Unlock pairs sit at positions one, two and, for six cycles, four, five.
// - After read/reset during erase, wait 10 us before trusting reads.
// - Identifier query: unlock pair then 90h at the command address.
// - Program: unlock pair, A0h at the command address, then the data write.
// - Block erase: unlock, 80h, unlock, 30h at the block address.
// - Further 30h confirms queue more blocks before the window closes.
module fci_host #(
    parameter int ERASE_WIN_CYCLES = fci_pkg::ERASE_WIN_CYC
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic byte_mode_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire fci_pkg::fci_op_t cmd_op_i,
    input wire logic [fci_pkg::ADDR_W-1:0] cmd_addr_i,
    input wire logic [fci_pkg::DATA_W-1:0] cmd_data_i,
    output logic rsp_valid_o,
    output logic [fci_pkg::DATA_W-1:0] rsp_data_o,
    output logic rsp_err_o,
    output logic erase_window_o,
    output logic [15:0] fl_addr_o,
    output logic [15:0] fl_dq_o,
    output logic [2:0] fl_dq_oe_o,
    input wire logic [15:0] fl_dq_i,
    output logic fl_ce_n_o,
    output logic fl_oe_n_o,
    output logic fl_we_n_o,
    output logic fl_byte_n_o
);
    import fci_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_WR_GO = 4'h1,
        S_WR_WAIT = 4'h2,
        S_RD_GO = 4'h3,
        S_RD_WAIT = 4'h4,
        S_PL_GO = 4'h5,
        S_PL_WAIT = 4'h6,
        S_RST_WAIT = 4'h7,
        S_RESP = 4'h8
    } fci_state_t;

    localparam logic [15:0] RST_WAIT_LAST = 16'(RESET_WAIT_CYC - 1);
    // Window closes early enough that a last accepted confirm still rises inside the timeout
    localparam logic [15:0] WIN_LOAD = 16'(ERASE_WIN_CYCLES - WE_LOW_CYC - WE_HIGH_CYC - 3);

    fci_cyc_if cyc ();

    // Number of writes in each command sequence
    function automatic logic [2:0] seq_len(input fci_op_t op);
        unique case (op)
            OP_IDENT_QUERY: seq_len = 3'd3;
            OP_PROGRAM: seq_len = 3'd4;
            OP_BLOCK_ERASE: seq_len = 3'd6;
            default: seq_len = 3'd1;
        endcase
    endfunction : seq_len

    // Address of one write of a sequence
    function automatic logic [ADDR_W-1:0] seq_addr(input fci_op_t op, input logic [2:0] step,
                                                  input logic bm, input logic [ADDR_W-1:0] ua);
        if (step == seq_len(op) - 3'd1 && op != OP_IDENT_QUERY)
            seq_addr = ua;
        else if (step == 3'd1 || step == 3'd4)
            seq_addr = bm ? UNLOCK2_BYTE_ADDR : UNLOCK2_WORD_ADDR;
        else
            seq_addr = bm ? UNLOCK1_BYTE_ADDR : UNLOCK1_WORD_ADDR;
    endfunction : seq_addr

    // Data of one write of a sequence
    function automatic logic [DATA_W-1:0] seq_data(input fci_op_t op, input logic [2:0] step,
                                                  input logic [DATA_W-1:0] ud);
        logic [7:0] c;
        c = UNLOCK1_DATA;
        if (op == OP_PROGRAM && step == 3'd3)
            return ud;
        if (op == OP_RESET)
            c = READ_RESET_CMD;
        else if (op == OP_ERASE_ADD || step == 3'd5)
            c = BLOCK_ERASE_CMD;
        else if (step == 3'd1 || step == 3'd4)
            c = UNLOCK2_DATA;
        else if (step == 3'd2)
            c = (op == OP_IDENT_QUERY) ? IDENT_QUERY_CMD :
                (op == OP_PROGRAM) ? PROGRAM_CMD : ERASE_SETUP_CMD;
        return {8'h00, c};
    endfunction : seq_data

    fci_state_t state, next_state;
    fci_op_t op, next_op;
    logic [2:0] step, next_step;
    logic [ADDR_W-1:0] uaddr, next_uaddr;
    logic [DATA_W-1:0] udata, next_udata;
    logic bm, next_bm;
    logic [DATA_W-1:0] prev, next_prev;
    logic have_prev, next_have_prev;
    logic err_seen, next_err_seen;
    logic fail, next_fail;
    logic erase_active, next_erase_active;
    logic [15:0] win_cnt, next_win_cnt;
    logic [15:0] wait_cnt, next_wait_cnt;
    logic rsp_valid, next_rsp_valid;
    logic [DATA_W-1:0] rsp_data, next_rsp_data;
    logic rsp_err, next_rsp_err;

    // Sequencer: unlock writes, command write, then status polling after a program
    always_comb begin
        next_state = state;
        next_op = op;
        next_step = step;
        next_uaddr = uaddr;
        next_udata = udata;
        next_bm = bm;
        next_prev = prev;
        next_have_prev = have_prev;
        next_err_seen = err_seen;
        next_fail = fail;
        next_erase_active = erase_active;
        next_win_cnt = (win_cnt != 16'h0000) ? win_cnt - 16'h0001 : win_cnt;
        next_wait_cnt = wait_cnt;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        next_rsp_err = rsp_err;
        unique case (state)
            S_IDLE: begin
                if (cmd_valid_i) begin
                    next_op = cmd_op_i;
                    next_uaddr = cmd_addr_i;
                    next_udata = cmd_data_i;
                    next_bm = byte_mode_i;
                    next_step = 3'd0;
                    next_fail = 1'b0;
                    next_have_prev = 1'b0;
                    next_err_seen = 1'b0;
                    next_rsp_data = 16'h0000;
                    if (cmd_op_i == OP_ERASE_ADD && win_cnt == 16'h0000) begin
                        next_rsp_err = 1'b1;
                        next_state = S_RESP;
                    end else if (cmd_op_i == OP_READ) begin
                        next_state = S_RD_GO;
                    end else if (cmd_op_i == OP_POLL) begin
                        next_state = S_PL_GO;
                    end else if (cmd_op_i == OP_SPARE) begin
                        next_rsp_err = 1'b1;
                        next_state = S_RESP;
                    end else begin
                        next_state = S_WR_GO;
                    end
                end
            end
            S_WR_GO: next_state = S_WR_WAIT;
            S_WR_WAIT: begin
                if (cyc.done) begin
                    next_step = step + 3'd1;
                    next_state = S_WR_GO;
                    if (step == seq_len(op) - 3'd1) begin
                        next_rsp_err = fail;
                        next_state = S_RESP;
                        unique case (op)
                            OP_BLOCK_ERASE, OP_ERASE_ADD: begin
                                next_win_cnt = WIN_LOAD;
                                next_erase_active = 1'b1;
                            end
                            OP_PROGRAM: next_state = S_PL_GO;
                            OP_RESET: begin
                                next_wait_cnt = 16'h0000;
                                next_win_cnt = 16'h0000;
                                if (erase_active)
                                    next_state = S_RST_WAIT;
                                next_erase_active = 1'b0;
                            end
                            default: next_state = S_RESP;
                        endcase
                    end
                end
            end
            S_RD_GO: next_state = S_RD_WAIT;
            S_RD_WAIT: begin
                if (cyc.done) begin
                    next_rsp_data = cyc.rdata;
                    next_rsp_err = 1'b0;
                    next_state = S_RESP;
                end
            end
            S_PL_GO: next_state = S_PL_WAIT;
            S_PL_WAIT: begin
                if (cyc.done) begin
                    next_prev = cyc.rdata;
                    next_have_prev = 1'b1;
                    next_state = S_PL_GO;
                    if (have_prev) begin
                        if (prev[TOGGLE_STATUS_BIT] == cyc.rdata[TOGGLE_STATUS_BIT]) begin
                            next_rsp_data = cyc.rdata;
                            next_rsp_err = 1'b0;
                            if (win_cnt == 16'h0000)
                                next_erase_active = 1'b0;
                            next_state = S_RESP;
                        end else if (err_seen) begin
                            next_rsp_data = cyc.rdata;
                            next_fail = 1'b1;
                            next_op = OP_RESET;
                            next_step = 3'd0;
                            next_state = S_WR_GO;
                        end else if (cyc.rdata[ERROR_STATUS_BIT]) begin
                            next_err_seen = 1'b1;
                            next_have_prev = 1'b0;
                        end
                    end
                end
            end
            S_RST_WAIT: begin
                next_wait_cnt = wait_cnt + 16'h0001;
                if (wait_cnt == RST_WAIT_LAST)
                    next_state = S_RESP;
            end
            S_RESP: begin
                next_rsp_valid = 1'b1;
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= S_IDLE;
            op <= OP_READ;
            step <= 3'd0;
            uaddr <= 17'h00000;
            udata <= 16'h0000;
            bm <= 1'b0;
            prev <= 16'h0000;
            have_prev <= 1'b0;
            err_seen <= 1'b0;
            fail <= 1'b0;
            erase_active <= 1'b0;
            win_cnt <= 16'h0000;
            wait_cnt <= 16'h0000;
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
            rsp_err <= 1'b0;
        end else begin
            state <= next_state;
            op <= next_op;
            step <= next_step;
            uaddr <= next_uaddr;
            udata <= next_udata;
            bm <= next_bm;
            prev <= next_prev;
            have_prev <= next_have_prev;
            err_seen <= next_err_seen;
            fail <= next_fail;
            erase_active <= next_erase_active;
            win_cnt <= next_win_cnt;
            wait_cnt <= next_wait_cnt;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            rsp_err <= next_rsp_err;
        end
    end

    assign cyc.req = (state == S_WR_GO) || (state == S_RD_GO) || (state == S_PL_GO);
    assign cyc.wr = (state == S_WR_GO);
    assign cyc.addr = (state == S_WR_GO) ? seq_addr(op, step, bm, uaddr) : uaddr;
    assign cyc.wdata = seq_data(op, step, udata);
    assign cyc.byte_mode = bm;

    fci_bus_cycle u_cycle (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .cyc(cyc),
        .fl_addr_o(fl_addr_o),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe_o(fl_dq_oe_o),
        .fl_dq_i(fl_dq_i),
        .fl_ce_n_o(fl_ce_n_o),
        .fl_oe_n_o(fl_oe_n_o),
        .fl_we_n_o(fl_we_n_o)
    );

    // Organisation pin follows the configuration of the current command
    assign fl_byte_n_o = ~bm;
    assign cmd_ready_o = (state == S_IDLE);
    assign rsp_valid_o = rsp_valid;
    assign rsp_data_o = rsp_data;
    assign rsp_err_o = rsp_err;
    assign erase_window_o = (win_cnt != 16'h0000);
endmodule : fci_host

// >>> fci_host_monitor.sv
`timescale 1ns/10ps
module fci_host_monitor #(
    parameter int ERASE_WIN_CYCLES = fci_pkg::ERASE_WIN_CYC
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_ready_o,
    input wire fci_pkg::fci_op_t cmd_op_i,
    input wire logic rsp_valid_o,
    input wire logic rsp_err_o,
    input wire logic erase_window_o,
    input wire logic [15:0] fl_addr_o,
    input wire logic [15:0] fl_dq_o,
    input wire logic [2:0] fl_dq_oe_o,
    input wire logic fl_ce_n_o,
    input wire logic fl_oe_n_o,
    input wire logic fl_we_n_o
);
    import fci_pkg::*;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // Strobe, select and bus direction agree; refused commands and the erase window span are checked too
    chk_write_select: assert property (!fl_we_n_o |-> !fl_ce_n_o && fl_oe_n_o)
        else $error("write strobe outside select");
    chk_write_drive: assert property (!fl_we_n_o |-> fl_dq_oe_o[0])
        else $error("write without data drive");
    chk_read_release: assert property (!fl_oe_n_o |-> fl_dq_oe_o[1:0] == 2'b00)
        else $error("read while driving data");
    chk_write_hold: assert property (!fl_we_n_o && !$past(fl_we_n_o) |->
        $stable(fl_addr_o) && $stable(fl_dq_o))
        else $error("address or data moved in write");
    chk_strobe_width: assert property ($fell(fl_we_n_o) |-> (!fl_we_n_o)[*5] ##1 fl_we_n_o)
        else $error("write strobe width");
    chk_rise_selected: assert property ($rose(fl_we_n_o) |-> !fl_ce_n_o)
        else $error("select lost before data latch");
    chk_refused_op: assert property (cmd_valid_i && cmd_ready_o && (cmd_op_i == OP_SPARE ||
        cmd_op_i == OP_ERASE_ADD && !erase_window_o) |-> fl_ce_n_o[*3] ##0 rsp_err_o)
        else $error("refused command not answered");
    chk_window_span: assert property ($rose(erase_window_o) |-> erase_window_o[*8])
        else $error("collection window cut short");
    cover property ($fell(fl_we_n_o));
    cover property ($rose(erase_window_o));
    cover property (rsp_valid_o && rsp_err_o);
endmodule : fci_host_monitor

bind fci_host fci_host_monitor #(.ERASE_WIN_CYCLES(ERASE_WIN_CYCLES)) u_mon (.mclk_i, .rstn_i,
    .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .rsp_valid_o, .rsp_err_o, .erase_window_o,
    .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o);

// >>> fci_flash_model.sv
`timescale 1ns/10ps
module fci_flash_model #(
    parameter logic [7:0] MFR_ID = 8'h3C, // Arbitrary value
    parameter logic [7:0] DEV_ID = 8'h5B // Arbitrary value
) (
    input wire logic [15:0] a_i,
    input wire logic [15:0] d_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic byte_n_i,
    output logic [15:0] q_o
);
    logic [15:0] mem [16];
    logic [15:0] la, val;
    logic [15:0] last = 16'h0000;
    logic [14:0] k;
    logic [7:0] c;
    logic [2:0] st = 3'h0;
    logic [2:0] bsy = 3'h0;
    logic md_id = 1'b0;
    logic ers = 1'b0;
    logic t6 = 1'b0;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    // key drops bits above 14, byte mode adds the extra low bit
    assign k = byte_n_i ? la[14:0] : {la[13:0], d_i[15]};
    assign c = d_i[7:0];
    // address taken at the falling strobe
    always @(negedge we_n_i) if (!ce_n_i) la <= a_i;
    always @(posedge we_n_i) if (!ce_n_i) begin
        if (c == 8'hF0) begin
            st <= 3'h0;
            md_id <= 1'b0;
            ers <= 1'b0;
        end else case (st)
            3'h0, 3'h3: st <= (c == 8'hAA && k == (byte_n_i ? 15'h5555 : 15'h2AAA)) ? st + 3'h1 : 3'h0;
            3'h1, 3'h4: st <= (c == 8'h55 && k == (byte_n_i ? 15'h2AAA : 15'h0555)) ? st + 3'h1 : 3'h0;
            3'h2: begin
                st <= c == 8'hA0 ? 3'h6 : c == 8'h80 ? 3'h3 : 3'h0;
                md_id <= c == 8'h90;
            end
            3'h6: begin
                mem[la[3:0]] <= mem[la[3:0]] & d_i;
                bsy <= 3'h3;
                st <= 3'h0;
            end
            default: begin
                st <= c == 8'h30 ? 3'h7 : 3'h0;
                ers <= c == 8'h30;
                if (c == 8'h30) foreach (mem[i]) mem[i] <= 16'hFFFF;
            end
        endcase
    end
    // status while busy or erasing, timer bit 1 while busy and 0 while erasing
    always_comb begin
        if (bsy != 3'h0) val = {8'h00, ~mem[a_i[3:0]][7], t6, 6'h0C};
        else if (ers) val = {8'h00, 1'b0, t6, 6'h04};
        else if (md_id) val = a_i[1] ? {15'h0, a_i[15:12] == 4'h1} : {8'h00, a_i[0] ? DEV_ID : MFR_ID};
        else val = mem[a_i[3:0]];
    end
    // Released bus shows the inverse of the last word, never a stale copy
    assign q_o = (!ce_n_i && !oe_n_i) ? val : ~last;
    always @(posedge oe_n_i) begin
        last <= val;
        if (bsy != 3'h0) begin
            bsy <= bsy - 3'h1;
            t6 <= ~t6;
        end
    end
endmodule : fci_flash_model

// >>> flash_command_interface_tb.sv
`timescale 1ns/10ps
module flash_command_interface_tb;
    import fci_pkg::*;
    localparam logic [7:0] MFR = 8'h3C; // Arbitrary value
    localparam logic [7:0] DEV = 8'h5B; // Arbitrary value
    logic mclk_i = 0, rstn_i = 0, byte_mode_i = 0, cmd_valid_i = 0, re;
    fci_op_t cmd_op_i = OP_READ;
    logic [ADDR_W-1:0] cmd_addr_i = '0;
    logic [DATA_W-1:0] cmd_data_i = '0, rsp_data_o, rd;
    logic [15:0] fl_addr_o, fl_dq_o, fl_dq_i;
    logic [2:0] fl_dq_oe_o;
    logic cmd_ready_o, rsp_valid_o, rsp_err_o, erase_window_o;
    logic fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_byte_n_o;
    int fail_count = 0, num_checks = 0;
    fci_host #(.ERASE_WIN_CYCLES(50)) DUT (.mclk_i, .rstn_i, .byte_mode_i, .cmd_valid_i,
        .cmd_ready_o, .cmd_op_i, .cmd_addr_i, .cmd_data_i, .rsp_valid_o, .rsp_data_o,
        .rsp_err_o, .erase_window_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_dq_i,
        .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o, .fl_byte_n_o);
    fci_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) u_flash (.a_i(fl_addr_o), .d_i(fl_dq_o),
        .ce_n_i(fl_ce_n_o), .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .byte_n_i(fl_byte_n_o),
        .q_o(fl_dq_i));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    // One command; held over exactly one taking edge, answer caught while it stands
    task automatic cmd(input fci_op_t op, input logic [16:0] a, input logic [15:0] d = '0,
        input logic bm = 1'b0);
        int n;
        n = 0;
        @(negedge mclk_i);
        cmd_op_i = op;
        cmd_addr_i = a;
        cmd_data_i = d;
        byte_mode_i = bm;
        cmd_valid_i = 1;
        @(negedge mclk_i) cmd_valid_i = 0;
        chk(16'(cmd_ready_o), 16'h0);
        while (rsp_valid_o !== 1'b1 && n < 5000) begin
            @(negedge mclk_i);
            n++;
        end
        rd = rsp_data_o;
        re = rsp_err_o;
        chk(16'(cmd_ready_o), 16'h1);
        chk(16'(n < 5000), 16'h1);
    endtask : cmd
    // query in either configuration, then leave it
    task automatic t_ident(input logic bm);
        cmd(OP_IDENT_QUERY, 17'h0, 16'h0, bm);
        cmd(OP_READ, 17'h0, 16'h0, bm);
        chk({8'h00, rd[7:0]}, {8'h00, MFR});
        cmd(OP_READ, bm ? 17'h00002 : 17'h00001, 16'h0, bm);
        chk({8'h00, rd[7:0]}, {8'h00, DEV});
        cmd(OP_READ, bm ? 17'h02004 : 17'h01002, 16'h0, bm);
        chk({8'h00, rd[7:0]}, 16'h0001);
        cmd(OP_READ, bm ? 17'h04004 : 17'h02002, 16'h0, bm);
        chk({8'h00, rd[7:0]}, 16'h0000);
        cmd(OP_RESET, 17'h0, 16'h0, bm);
        cmd(OP_READ, bm ? 17'h00006 : 17'h00003, 16'h0, bm);
        chk({8'h00, rd[7:0]}, 16'h00FF);
    endtask : t_ident
    // program twice; second may only clear bits
    task automatic t_prog();
        cmd(OP_PROGRAM, 17'h3, 16'h5A3C);
        chk(16'(re), 16'h0);
        cmd(OP_READ, 17'h3);
        chk(rd, 16'h5A3C);
        cmd(OP_PROGRAM, 17'h3, 16'hFF0F);
        cmd(OP_READ, 17'h3);
        chk(rd, 16'h5A0C);
        cmd(OP_POLL, 17'h3);
        chk(rd, 16'h5A0C);
    endtask : t_prog
    // erase, queue a block, then a late confirm and a spare code
    task automatic t_erase();
        cmd(OP_BLOCK_ERASE, 17'h01000);
        chk(16'(erase_window_o), 16'h1);
        cmd(OP_READ, 17'h01000);
        chk(16'(rd[3]), 16'h0);
        chk(16'(rd[7]), 16'h0);
        cmd(OP_ERASE_ADD, 17'h02000);
        chk(16'(re), 16'h0);
        repeat (30) @(negedge mclk_i);
        chk(16'(erase_window_o), 16'h1);
        repeat (20) @(negedge mclk_i);
        chk(16'(erase_window_o), 16'h0);
        cmd(OP_ERASE_ADD, 17'h03000);
        chk(16'(re), 16'h1);
        cmd(OP_SPARE, 17'h0);
        chk(16'(re), 16'h1);
        chk(rd, 16'h0000);
        cmd(OP_RESET, 17'h0);
        cmd(OP_READ, 17'h3);
        chk(rd, 16'hFFFF);
    endtask : t_erase
    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    initial forever #5 mclk_i = ~mclk_i;
    initial begin
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i) rstn_i = 1;
        t_ident(1'b0);
        t_ident(1'b1);
        t_prog();
        t_erase();
        finish_test();
    end
    // Whole run is a few thousand cycles; this is far past it
    initial begin
        #300us;
        fail_count++;
        finish_test();
    end
endmodule : flash_command_interface_tb
